// *** hw/bpgc_pkg.sv ***
package bpgc_pkg;
  // ********************************
  // Widths
  // ********************************
  localparam int AD_W      = 32;
  localparam int CBE_W     = 4;
  // ********************************
  // Command register width and bit positions
  // ********************************
  localparam int CMD_W     = 16;
  localparam int CMD_PER   = 6;
  localparam int CMD_SERR  = 8;
  // ********************************
  // Status register bit positions
  // ********************************
  localparam int STAT_DPE  = 15;
  // ********************************
  // Timing, in clocks
  // ********************************
  localparam int PAR_LAG    = 1;
  localparam int PERR_DELAY = 2;
  // ********************************
  // Checker pipeline states
  // ********************************
  typedef enum logic [2:0] {
    BPGC_IDLE  = 3'b001,
    BPGC_ADDR  = 3'b010,
    BPGC_DATA  = 3'b100
  } bpgc_phase_t;
endpackage

// *** hw/bpgc_if.sv ***
interface bpgc_if;
  import bpgc_pkg::*;
  // Shared bus lines, resolved by the bench from the enables
  logic [AD_W-1:0]  ad;
  logic [CBE_W-1:0] cbe_n;
  logic             par;
  logic             serr_n;
  logic             perr_n;
  // Phase qualifiers seen on the bus
  logic             addr_phase;
  logic             data_xfer;
  // Generator end drives
  logic [AD_W-1:0]  gen_ad_o;
  logic             gen_ad_oe;
  logic [CBE_W-1:0] gen_cbe_o;
  logic             gen_par_o;
  logic             gen_par_oe;
  // Checker end drives
  logic             chk_serr_o;
  logic             chk_serr_oe;
  logic             chk_perr_o;
  logic             chk_perr_oe;

  modport gen_end (
    input  ad, cbe_n, par, serr_n, perr_n, addr_phase, data_xfer,
    output gen_ad_o, gen_ad_oe, gen_cbe_o, gen_par_o, gen_par_oe
  );
  modport chk_end (
    input  ad, cbe_n, par, serr_n, perr_n, addr_phase, data_xfer,
    output chk_serr_o, chk_serr_oe, chk_perr_o, chk_perr_oe
  );
endinterface

// *** hw/bpgc_gen.sv ***
// Bus agent end that drives AD, C/BE# and even parity one clock later
module bpgc_gen
  import bpgc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             resetn_in,
  // User side
  input  wire logic             drive_in,
  input  wire logic [AD_W-1:0]  ad_in,
  input  wire logic [CBE_W-1:0] cbe_n_in,
  output logic                  par_busy_out,
  // Bus side
  bpgc_if.gen_end               bus
);
  // ********************************
  // Address/data drive
  // ********************************
  logic [AD_W-1:0]  ad_q;
  logic [CBE_W-1:0] cbe_q;
  logic             ad_oe;
  logic             par_q;
  logic             par_oe;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      ad_q  <= '0;
      cbe_q <= '1;
      ad_oe <= 1'b0;
    end else begin
      ad_q  <= ad_in;
      cbe_q <= cbe_n_in;
      ad_oe <= drive_in;
    end
  end

  // ********************************
  // Parity, lagging by one clock
  // ********************************
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      par_q  <= 1'b0;
      par_oe <= 1'b0;
    end else begin
      par_q  <= ^{ad_q, cbe_q};
      par_oe <= ad_oe;
    end
  end

  assign bus.gen_ad_o   = ad_q;
  assign bus.gen_ad_oe  = ad_oe;
  assign bus.gen_cbe_o  = cbe_q;
  assign bus.gen_par_o  = par_q;
  assign bus.gen_par_oe = par_oe;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      par_busy_out <= 1'b0;
    end else begin
      par_busy_out <= ad_oe;
    end
  end
endmodule

// *** hw/bpgc_chk.sv ***
// Notes on behaviour
// - AD driver also drives even parity
// - Ones over AD, C/BE#, parity even
// - Idle byte lanes stable, still in parity
// - Undefined address lines stable and covered
// - Parity identical everywhere, never optional
// - Parity one clock after its word
// - Parity ownership follows AD ownership
// - Initiator address/write, target read parity
// - Device checks received address and data
// - Flag address parity error per phase
// - Set detected parity error status bit
// - Enabled, selected: complete, abort, or ignore
// - Never Retry solely for parity error
// - Interrupt acknowledge address carries valid parity
// - Data parity error two clocks later
// - Response disabled: ignore data parity error
// - System error needs both enables set
// - System error driven one clock, released
module bpgc_chk
  import bpgc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             resetn_in,
  // Configuration
  input  wire logic [CMD_W-1:0] command_in,
  input  wire logic             selected_in,
  input  wire logic             status_clr_in,
  // Status and response
  output logic [CMD_W-1:0]      status_out,
  output logic                  addr_perr_out,
  output logic                  data_perr_out,
  output logic                  abort_req_out,
  output logic                  parity_ok_out,
  // Bus side
  bpgc_if.chk_end               bus
);
  // ********************************
  // Sampling stage
  // ********************************
  bpgc_phase_t      phase;
  logic             word_par;
  logic             mismatch;
  logic             addr_err;
  logic             data_err;
  logic             per_en;
  logic             serr_en;

  assign per_en  = command_in[CMD_PER];
  assign serr_en = command_in[CMD_SERR];

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      word_par <= 1'b0;
      phase    <= BPGC_IDLE;
    end else begin
      word_par <= ^{bus.ad, bus.cbe_n};
      if (bus.addr_phase) begin
        phase <= BPGC_ADDR;
      end else if (bus.data_xfer) begin
        phase <= BPGC_DATA;
      end else begin
        phase <= BPGC_IDLE;
      end
    end
  end

  // ********************************
  // Compare against lagged parity
  // ********************************
  assign mismatch = word_par ^ bus.par;
  assign addr_err = (phase == BPGC_ADDR) && mismatch;
  assign data_err = (phase == BPGC_DATA) && mismatch;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      addr_perr_out <= 1'b0;
      parity_ok_out <= 1'b0;
    end else begin
      addr_perr_out <= addr_err;
      parity_ok_out <= (phase != BPGC_IDLE) && !mismatch;
    end
  end

  // Detected parity error, set wins over clear
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      status_out <= '0;
    end else if (addr_err || data_err) begin
      status_out[STAT_DPE] <= 1'b1;
    end else if (status_clr_in) begin
      status_out[STAT_DPE] <= 1'b0;
    end
  end

  // Target-Abort chosen; never Retry for parity
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      abort_req_out <= 1'b0;
    end else begin
      abort_req_out <= addr_err && per_en && selected_in;
    end
  end

  // ********************************
  // Data parity error line
  // ********************************
  // Driven the clock after the check, so seen two edges after completion
  logic perr_drv;
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      perr_drv      <= 1'b0;
      data_perr_out <= 1'b0;
    end else begin
      perr_drv      <= data_err && per_en;
      data_perr_out <= data_err && per_en;
    end
  end
  assign bus.chk_perr_o  = 1'b0;
  assign bus.chk_perr_oe = perr_drv;

  // ********************************
  // System error line
  // ********************************
  logic serr_drv;
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      serr_drv <= 1'b0;
    end else begin
      // One pulse per report, also over both phases of a dual cycle
      serr_drv <= addr_err && per_en && serr_en && !serr_drv;
    end
  end
  assign bus.chk_serr_o  = 1'b0;
  assign bus.chk_serr_oe = serr_drv;
endmodule

// *** testbench/bpgc_asserts.sv ***
module bpgc_asserts
  import bpgc_pkg::*;
(
  // Clock and reset
  input wire logic             clk_sys_in,
  input wire logic             resetn_in,
  // Bus lines
  input wire logic [AD_W-1:0]  ad,
  input wire logic [CBE_W-1:0] cbe_n,
  input wire logic             par,
  input wire logic             addr_phase,
  input wire logic             data_xfer,
  // End drives
  input wire logic [AD_W-1:0]  gen_ad_o,
  input wire logic             gen_ad_oe,
  input wire logic [CBE_W-1:0] gen_cbe_o,
  input wire logic             gen_par_o,
  input wire logic             gen_par_oe,
  input wire logic             chk_serr_oe,
  input wire logic             chk_perr_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);
  par_lag_a: assert property (gen_ad_oe |=> gen_par_oe) else $error("par enable late");
  par_own_a: assert property (!gen_ad_oe |=> !gen_par_oe) else $error("par driven alone");
  par_even_a: assert property (gen_ad_oe |=> gen_par_o == ^{$past(gen_ad_o), $past(gen_cbe_o)})
    else $error("odd parity");
  serr_pulse_a: assert property (chk_serr_oe |=> !chk_serr_oe) else $error("serr too long");
  serr_cause_a: assert property (chk_serr_oe |->
    $past(addr_phase, 2) && ^{$past(ad, 2), $past(cbe_n, 2), $past(par)})
    else $error("serr without error");
  serr_quiet_a: assert property (addr_phase ##1 !(^{$past(ad), $past(cbe_n), par}) |=> !chk_serr_oe)
    else $error("serr on good address");
  perr_cause_a: assert property (chk_perr_oe |->
    $past(data_xfer, 2) && ^{$past(ad, 2), $past(cbe_n, 2), $past(par)})
    else $error("perr without error");
  perr_quiet_a: assert property (data_xfer ##1 !(^{$past(ad), $past(cbe_n), par}) |=> !chk_perr_oe)
    else $error("perr on good data");
endmodule

// *** testbench/bus_parity_gen_check_tb_top.sv ***
module bus_parity_gen_check_tb_top;
  import bpgc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk_sys_in, resetn_in, drive_in, sel, clr, busy, ok1, aerr1, aerr2, derr2, abort2, ok2;
  logic [AD_W-1:0]  ad_in, w0, w1, rnd;
  logic [CBE_W-1:0] cbe_n_in, c0, c1;
  logic [CMD_W-1:0] cmd, stat1, stat2;
  logic [3:0]       hd, hk, ha, hv, he, hl;
  logic             se, sp;
  int               seed = 32'h89ab;
  int               error_cnt = 0;
  int               total_checks = 0;
  bpgc_if b1();
  bpgc_if b2();
  // Released AD, C/BE# and PAR show changing junk; released SERR#/PERR# read high
  assign b1.ad = b1.gen_ad_oe ? b1.gen_ad_o : rnd;
  assign b1.cbe_n = b1.gen_ad_oe ? b1.gen_cbe_o : rnd[3:0];
  assign b1.par = b1.gen_par_oe ? b1.gen_par_o : rnd[4];
  assign b1.serr_n = !b1.chk_serr_oe;
  assign b1.perr_n = !b1.chk_perr_oe;
  assign b2.serr_n = !b2.chk_serr_oe;
  assign b2.perr_n = !b2.chk_perr_oe;
  bpgc_gen bpgc_gen_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .drive_in(drive_in), .ad_in(ad_in),
    .cbe_n_in(cbe_n_in), .par_busy_out(busy), .bus(b1));
  bpgc_chk bpgc_chk_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .command_in(cmd), .selected_in(sel),
    .status_clr_in(clr), .status_out(stat1), .addr_perr_out(aerr1), .data_perr_out(), .abort_req_out(),
    .parity_ok_out(ok1), .bus(b1));
  bpgc_chk bpgc_chk2_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .command_in(cmd), .selected_in(sel),
    .status_clr_in(clr), .status_out(stat2), .addr_perr_out(aerr2), .data_perr_out(derr2),
    .abort_req_out(abort2), .parity_ok_out(ok2), .bus(b2));
  // Generator checked on b1, error lines on b2 where errors are injected
  bpgc_asserts bpgc_asserts_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ad(b2.ad), .cbe_n(b2.cbe_n),
    .par(b2.par), .addr_phase(b2.addr_phase), .data_xfer(b2.data_xfer), .gen_ad_o(b1.gen_ad_o),
    .gen_ad_oe(b1.gen_ad_oe), .gen_cbe_o(b1.gen_cbe_o), .gen_par_o(b1.gen_par_o), .gen_par_oe(b1.gen_par_oe),
    .chk_serr_oe(b2.chk_serr_oe), .chk_perr_oe(b2.chk_perr_oe));
  task automatic chk(input logic [AD_W-1:0] seen, input logic [AD_W-1:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    error_cnt++;
    give_verdict();
  end
  // ********************************
  // Random traffic, all enable modes
  // ********************************
  initial begin
    {resetn_in, drive_in, ad_in, cbe_n_in, sel, clr, cmd, rnd, hd, hk, ha, hv, he, hl, w0, w1, c0, c1} = '0;
    {sp, b1.addr_phase, b1.data_xfer, b2.addr_phase, b2.data_xfer, b2.ad, b2.cbe_n, b2.par} = '0;
    repeat (12) @(negedge clk_sys_in);
    resetn_in = 1'b1;
    for (int m = 0; m < 4; m++) begin
      cmd[CMD_PER] = m[0];
      cmd[CMD_SERR] = m[1];
      repeat (200) begin
        @(negedge clk_sys_in);
        chk(b1.gen_ad_oe, hd[0], "ad_oe");
        if (hd[0]) chk(b1.ad, w0, "ad");
        chk(b1.gen_par_oe, hd[1], "par_oe");
        if (hd[1]) chk(b1.par, ^{w1, c1}, "par");
        chk(busy, hd[1], "busy");
        chk(ok1, hd[2], "ok1");
        chk(aerr1, 0, "aerr1");
        chk(stat1, 0, "stat1");
        chk(aerr2, ha[1] & he[0], "aerr2");
        chk(derr2, hv[1] & he[0] & m[0], "derr2");
        chk(abort2, ha[1] & he[0] & m[0] & hl[0], "abort");
        chk(ok2, (ha[1] | hv[1]) & !he[0], "ok2");
        se = ha[1] & he[0] & m[0] & m[1] & !sp;
        chk(b2.serr_n, !se, "serr_n");
        sp = se;
        chk(b2.perr_n, !(hv[1] & he[0] & m[0]), "perr_n");
        if ((ha[1] | hv[1]) & he[0]) chk(stat2[STAT_DPE], 1, "status");
        b1.addr_phase = hd[0] & hk[0];
        b1.data_xfer = hd[0] & !hk[0];
        rnd = $random(seed);
        ad_in = $random(seed);
        drive_in = rnd[5] | rnd[6];
        cbe_n_in = rnd[11:8];
        sel = rnd[12];
        // Parity of last word, flipped on purpose when rnd[13] is set
        b2.par = ^{b2.ad, b2.cbe_n} ^ rnd[13];
        b2.ad = $random(seed);
        b2.cbe_n = rnd[17:14];
        b2.addr_phase = rnd[18] & rnd[19];
        b2.data_xfer = rnd[18] & !rnd[19];
        hd = {hd[2:0], drive_in};
        hk = {hk[2:0], rnd[7]};
        ha = {ha[2:0], b2.addr_phase};
        hv = {hv[2:0], b2.data_xfer};
        he = {he[2:0], rnd[13]};
        hl = {hl[2:0], sel};
        {w1, w0, c1, c0} = {w0, ad_in, c0, cbe_n_in};
      end
    end
    {b2.addr_phase, b2.data_xfer, clr} = 3'h1;
    repeat (4) @(negedge clk_sys_in);
    chk(stat2, 0, "cleared");
    give_verdict();
  end
endmodule
